// ===== hdl/port4_mode_ctrl.sv
// mode, termination, slew and driver control for the fourth serial port
`timescale 1ns/1ps
`include "port4_params.svh"
module port4_mode_ctrl #(
  parameter int EXP_WIDTH = `P4_EXP_WIDTH
) (
  input wire logic clk, // system clock, 250 MHz
  input wire logic sys_rst, // async reset, active high
  input wire logic exp1_we, // pulse: load expander one image
  input wire logic [EXP_WIDTH-1:0] expander_one_line, // expander one output image
  input wire logic exp2_we, // pulse: load expander two image
  input wire logic [EXP_WIDTH-1:0] expander_two_line, // expander two output image
  input wire logic uart_txd, // uart serial data out, same clock
  input wire logic uart_rts_n, // uart request-to-send, active low
  input wire logic line_rxd, // receive pin from transceiver
  output logic line_txd, // data to transceiver driver
  output logic uart_rxd, // data to uart receiver
  output port4_pkg::line_cfg_s cfg, // mode, termination, slew lines
  output port4_pkg::xcvr_ctl_s xcvr, // driver and receiver enables
  output port4_pkg::line_mode_e mode // decoded line mode
);
  logic hd_q;
  logic term_n_q;
  logic slew_n_q;
  logic rx_sync;
  logic drv_en_q;
  logic txd_q;
  logic rxd_q;

  port4_sync u_rx_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(line_rxd),
    .q(rx_sync)
  );

  // expander one holds mode and termination; reset gives RS485 and no termination
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hd_q <= `P4_HALF_DUPLEX_RST;
      term_n_q <= `P4_TERM_N_RST;
    end else if (exp1_we) begin
      hd_q <= expander_one_line[`P4_HALF_DUPLEX_BIT];
      term_n_q <= expander_one_line[`P4_TERM_BIT];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slew_n_q <= `P4_SLEW_N_RST;
    end else if (exp2_we) begin
      slew_n_q <= expander_two_line[`P4_SLEW_BIT];
    end
  end

  // full duplex keeps the driver on; half duplex follows request-to-send
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      drv_en_q <= 1'h0;
    end else begin
      drv_en_q <= hd_q ? ~uart_rts_n : 1'h1;
    end
  end

  // registered data paths; in half duplex with the driver on, the echo is taken from txd_q, not from the pin
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      txd_q <= 1'h1;
      rxd_q <= 1'h1;
    end else begin
      txd_q <= uart_txd;
      rxd_q <= (hd_q && drv_en_q) ? txd_q : rx_sync;
    end
  end

  assign line_txd = txd_q;
  assign uart_rxd = rxd_q;
  assign cfg.half_duplex_select = hd_q;
  assign cfg.termination_n = term_n_q;
  assign cfg.slew_limit_n = slew_n_q;
  assign xcvr.drv_en = drv_en_q;
  // receiver never gated off, but uart_rxd takes the echo instead of the pin while the half-duplex driver is on
  assign xcvr.rcv_en = 1'h1;
  assign mode = hd_q ? port4_pkg::mode_half_duplex : port4_pkg::mode_full_duplex;

  // some antecedents carry !sys_rst so an attempt on the release edge is not judged against reset
  property p_mode_load;
    @(posedge clk) disable iff (sys_rst)
      !sys_rst && exp1_we |=> hd_q == $past(expander_one_line[`P4_HALF_DUPLEX_BIT]);
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode not loaded");

  property p_term_load;
    @(posedge clk) disable iff (sys_rst)
      !sys_rst && exp1_we |=> term_n_q == $past(expander_one_line[`P4_TERM_BIT]);
  endproperty
  a_term_load: assert property (p_term_load) else $error("termination not loaded");

  property p_slew_load;
    @(posedge clk) disable iff (sys_rst)
      !sys_rst && exp2_we |=> slew_n_q == $past(expander_two_line[`P4_SLEW_BIT]);
  endproperty
  a_slew_load: assert property (p_slew_load) else $error("slew not loaded");

  property p_hold;
    @(posedge clk) disable iff (sys_rst)
      !exp1_we |=> $stable(hd_q) && $stable(term_n_q);
  endproperty
  a_hold: assert property (p_hold) else $error("config changed without write");

  sequence s_rts_off_hd;
    hd_q && uart_rts_n;
  endsequence
  property p_drv_off;
    @(posedge clk) disable iff (sys_rst)
      s_rts_off_hd ##1 hd_q |-> !xcvr.drv_en;
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("driver on with rts high");

  property p_drv_on;
    @(posedge clk) disable iff (sys_rst)
      (!sys_rst && (!hd_q || !uart_rts_n)) ##1 1'b1 |-> xcvr.drv_en;
  endproperty
  a_drv_on: assert property (p_drv_on) else $error("driver not on");

  sequence s_echo_src;
    hd_q && drv_en_q;
  endsequence
  property p_echo;
    @(posedge clk) disable iff (sys_rst)
      s_echo_src |=> uart_rxd == $past(txd_q);
  endproperty
  a_echo: assert property (p_echo) else $error("echo missing");

  property p_tx_path;
    @(posedge clk) disable iff (sys_rst)
      !sys_rst |=> line_txd == $past(uart_txd);
  endproperty
  a_tx_path: assert property (p_tx_path) else $error("tx path delay wrong");

  property p_rcv;
    @(posedge clk) disable iff (sys_rst)
      !xcvr.drv_en |-> xcvr.rcv_en;
  endproperty
  a_rcv: assert property (p_rcv) else $error("receiver disabled");

  // the first edge after release still shows the mode, termination, slew and driver-enable reset levels
  property p_rst_state;
    @(posedge clk) $fell(sys_rst) |-> hd_q && term_n_q && slew_n_q && !drv_en_q;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("reset levels wrong");

  property p_slew_hold;
    @(posedge clk) disable iff (sys_rst)
      !exp2_we |=> $stable(slew_n_q);
  endproperty
  a_slew_hold: assert property (p_slew_hold) else $error("slew changed without write");

  property p_mode_hd;
    @(posedge clk) disable iff (sys_rst)
      cfg.half_duplex_select |-> mode == port4_pkg::mode_half_duplex;
  endproperty
  a_mode_hd: assert property (p_mode_hd) else $error("half duplex not decoded");

  property p_mode_fd;
    @(posedge clk) disable iff (sys_rst)
      !cfg.half_duplex_select |-> mode == port4_pkg::mode_full_duplex;
  endproperty
  a_mode_fd: assert property (p_mode_fd) else $error("full duplex not decoded");

  sequence s_rts_rise_hd;
    hd_q && $rose(uart_rts_n);
  endsequence
  property p_rts_release;
    @(posedge clk) disable iff (sys_rst)
      s_rts_rise_hd |=> !xcvr.drv_en;
  endproperty
  a_rts_release: assert property (p_rts_release) else $error("driver kept on");

  property p_fd_drv;
    @(posedge clk) disable iff (sys_rst)
      !sys_rst && $fell(hd_q) |=> xcvr.drv_en;
  endproperty
  a_fd_drv: assert property (p_fd_drv) else $error("driver off in full duplex");

  // with the driver off, or in full duplex, the uart hears the pin three flops late
  sequence s_listen;
    !sys_rst && !(hd_q && drv_en_q);
  endsequence
  property p_rx_pin;
    @(posedge clk) disable iff (sys_rst)
      s_listen |=> uart_rxd == $past(rx_sync);
  endproperty
  a_rx_pin: assert property (p_rx_pin) else $error("receive not from pin");

  // echo end to end: uart output back at the uart input two cycles later
  sequence s_echo_run;
    !sys_rst ##1 s_echo_src;
  endsequence
  property p_echo_pair;
    @(posedge clk) disable iff (sys_rst)
      s_echo_run |=> uart_rxd == $past(uart_txd, 2);
  endproperty
  a_echo_pair: assert property (p_echo_pair) else $error("echo late");

  // every uart data edge reaches line_txd one cycle later, and no other edge does
  sequence s_txd_edge;
    !sys_rst ##1 (!sys_rst && $changed(uart_txd));
  endsequence
  property p_txd_edge;
    @(posedge clk) disable iff (sys_rst)
      s_txd_edge |=> $changed(line_txd);
  endproperty
  a_txd_edge: assert property (p_txd_edge) else $error("tx edge lost");

  sequence s_txd_still;
    !sys_rst ##1 (!sys_rst && $stable(uart_txd));
  endsequence
  property p_txd_still;
    @(posedge clk) disable iff (sys_rst)
      s_txd_still |=> $stable(line_txd);
  endproperty
  a_txd_still: assert property (p_txd_still) else $error("tx edge added");
endmodule // port4_mode_ctrl

// ===== hdl/port4_params.svh
// constants for the fourth serial port mode control block
`ifndef PORT4_PARAMS_SVH
`define PORT4_PARAMS_SVH
`define P4_HALF_DUPLEX_BIT 15
`define P4_TERM_BIT 16
`define P4_SLEW_BIT 6
`define P4_EXP1_ADDR 7'h21
`define P4_EXP2_ADDR 7'h22
`define P4_HALF_DUPLEX_RST 1'h1
`define P4_TERM_N_RST 1'h1
`define P4_SLEW_N_RST 1'h1
`define P4_CLK_HZ 250000000
`define P4_MAX_BAUD_TENTHS 9216
`define P4_MIN_BIT_CYCLES (`P4_CLK_HZ / (`P4_MAX_BAUD_TENTHS * 100))
`define P4_EXP_WIDTH 17
`endif

// ===== hdl/port4_pkg.sv
// types for the fourth serial port mode control block
package port4_pkg;
  typedef enum logic {mode_full_duplex, mode_half_duplex} line_mode_e;
  typedef struct packed {
    logic half_duplex_select;
    logic termination_n;
    logic slew_limit_n;
  } line_cfg_s;
  typedef struct packed {
    logic drv_en;
    logic rcv_en;
  } xcvr_ctl_s;
endpackage

// ===== hdl/port4_sync.sv
// two-stage synchroniser for the receive pin
`timescale 1ns/1ps
module port4_sync (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic d, // asynchronous level
  output logic q // synchronised level
);
  logic meta_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 1'h1;
      q <= 1'h1;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // port4_sync

// ===== dv/remote_node.sv
// remote rs485 node on the far side of the fourth serial port
`timescale 1ns/1ps
module remote_node (
  input wire logic clk, // system clock
  input wire logic talk, // remote node wants to send
  input wire logic drv_on, // local driver owns the pair
  input wire logic txd, // local driver data
  output logic rxd // level at the local receiver
);
  initial rxd = 1'h1;
  always @(posedge clk) begin
    if (drv_on) begin
      rxd <= txd;
    end else begin
      // fail-safe bias holds an undriven pair at mark
      rxd <= talk ? 1'($urandom) : 1'h1;
    end
  end
endmodule // remote_node

// ===== dv/testbench.sv
// self-checking bench for the fourth serial port mode control
`timescale 1ns/1ps
module testbench;
  logic clk = 1'h0;
  logic sys_rst, exp1_we, exp2_we, uart_txd, uart_rts_n, line_rxd, line_txd, uart_rxd, talk;
  logic [16:0] e1, e2;
  port4_pkg::line_cfg_s cfg;
  port4_pkg::xcvr_ctl_s xcvr;
  port4_pkg::line_mode_e mode;
  int n_fail = 0, check_count = 0, cyc = 0;
  logic [2:0] m_cfg;
  logic m_drv, m_txd, m_rxd;
  logic pin_q[$];
  port4_mode_ctrl u_port4_mode_ctrl (.clk(clk), .sys_rst(sys_rst), .exp1_we(exp1_we),
    .expander_one_line(e1), .exp2_we(exp2_we), .expander_two_line(e2), .uart_txd(uart_txd),
    .uart_rts_n(uart_rts_n), .line_rxd(line_rxd), .line_txd(line_txd), .uart_rxd(uart_rxd),
    .cfg(cfg), .xcvr(xcvr), .mode(mode));
  remote_node u_remote_node (.clk(clk), .talk(talk),
    .drv_on(xcvr.drv_en & cfg.half_duplex_select), .txd(line_txd), .rxd(line_rxd));
  task automatic close_out();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic void chk(bit ok, string s);
    check_count++;
    if (!ok) begin
      n_fail++;
      $display("Error %0t %s mismatch", $time, s);
    end
  endfunction
  // reference model; blocking order matters, old values feed the later lines
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      m_cfg = 3'h7;
      {m_drv, m_txd, m_rxd} = 3'h3;
      pin_q = '{1'h1, 1'h1};
    end else begin
      m_rxd = (m_cfg[2] && m_drv) ? m_txd : pin_q[0];
      pin_q.push_back(line_rxd);
      pin_q.delete(0);
      m_txd = uart_txd;
      m_drv = m_cfg[2] ? !uart_rts_n : 1'h1;
      if (exp1_we) m_cfg[2:1] = {e1[15], e1[16]};
      if (exp2_we) m_cfg[0] = e2[6];
    end
  end
  always @(negedge clk) begin
    chk(cfg === m_cfg && mode === port4_pkg::line_mode_e'(m_cfg[2]), "cfg");
    chk(xcvr.drv_en === m_drv && line_txd === m_txd, "driver");
    chk(uart_rxd === m_rxd && xcvr.rcv_en === 1'h1, "receive");
    cyc++;
    if (cyc > 4000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    forever #2 clk = ~clk;
  end
  initial begin
    void'($urandom(32'h323B3B03));
    {sys_rst, exp1_we, exp2_we, uart_txd, uart_rts_n, talk} = 6'h26;
    {e1, e2} = 34'h0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    $display("test reset done");
    for (int i = 0; i < 300; i++) begin
      // let the echo of the last data bit return before rts may rise
      repeat (2) @(posedge clk);
      // board ends the network only in the first half, so termination stays off later
      e1 <= 17'($urandom) | ((i < 150) ? 17'h00000 : 17'h10000);
      e2 <= 17'($urandom);
      // a write pulse stands for a finished 7-bit write at 100KB/s or 400KB/s to 0x21 or 0x22
      exp1_we <= (i != 150) && 1'($urandom);
      exp2_we <= (i != 150) && 1'($urandom);
      uart_rts_n <= 1'($urandom);
      talk <= 1'($urandom);
      sys_rst <= (i == 150);
      repeat ($urandom_range(1, 6)) begin
        @(posedge clk);
        uart_txd <= 1'($urandom);
        {exp1_we, exp2_we, sys_rst} <= 3'h0;
      end
    end
    $display("test random traffic done");
    close_out();
  end
endmodule // testbench
